// ### verilog/acp_parser.sv
// Notes on behaviour
// - Abort a running measurement on setup, init, start or reset commands.
// - Measurement control aborts only for certain written values.
// - Colons are plain header characters, never hierarchy separators.
// - Parameters and returned values are separated by commas.
// - Headers hold no white space; such headers are not accepted.
// - Keyword matching ignores letter case.
// - Only full keyword spellings are recognised, no short forms.
// - Identification reply: maker, model, serial, colon-joined revisions.
// - Reset command restores every setting to its reset state.
// - Reset command leaves calibration constants untouched.
// - Self-test answers zero when every result is within limits.
// - Self-test answers one and queues an error when a result fails.
// - Self-test duration scales with installed sample memory.
// - Digital stage: full-scale front end, zoom, filter, decimation.
// - Noise stage: short acquisition with input disconnected.
// - Bump stage: converter-related front-end levels checked.
// - Memory stage: fill whole sample memory, read back and compare.
// - Analog stage: autozero works and input produces a trigger.
// - A failing self-test leaves an entry for later error queries.
// - Unknown but byte-swapped looking codes get a distinct error.
`timescale 1ns/10ps
module acp_parser #(
   parameter int unsigned TENTH_MIN_CYC = acp_pkg::TENTH_MIN_CYC
) (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_valid_i,
   output logic             rx_ready_o,
   output logic [7:0]       tx_data_o,
   output logic             tx_valid_o,
   output logic             tx_last_o,
   input  wire logic        tx_ready_i,
   output logic             cmd_strobe_o,
   output logic [4:0]       cmd_code_o,
   output logic [15:0]      cmd_param_o,
   output logic [3:0]       cmd_nparam_o,
   output logic             abort_o,
   output logic             settings_rst_o,
   output logic             st_start_o,
   output logic [2:0]       st_stage_o,
   input  wire logic        st_done_i,
   input  wire logic        st_fail_i,
   input  wire logic [1:0]  mem_size_i,
   input  wire logic        err_pop_i,
   output logic [7:0]       err_code_o,
   output logic             err_avail_o
);
   typedef enum logic [1:0] {M_RECV, M_EXEC, M_TEST, M_SEND} acp_state_type;

   acp_state_type               state;
   acp_state_type               next_state;
   logic [acp_pkg::HDR_W-1:0]   hdr;
   logic [acp_pkg::HDR_W-1:0]   hdr_swap;
   logic [4:0]                  hlen;
   logic                        over;
   logic                        in_par;
   logic                        field_empty;
   logic                        bad;
   logic [3:0]                  ncomma;
   logic [15:0]                 pval;
   logic [7:0]                  ch;
   logic                        is_ws;
   logic                        rx_fire;
   logic                        hit;
   logic [4:0]                  kw_idx;
   logic                        swap_hit;
   logic                        par_bad;
   logic                        exec_ok;
   logic [2:0]                  stage;
   logic                        fail;
   logic [31:0]                 pre;
   logic [7:0]                  tenths;
   logic [7:0]                  limit;
   logic                        timeout;
   logic                        st_finish;
   logic                        st_result_fail;
   logic                        resp_idn;
   logic [5:0]                  ptr;
   logic                        err_push;
   logic [7:0]                  err_val;
   logic [7:0]                  eq_mem [acp_pkg::EQ_DEPTH];
   logic [2:0]                  eq_wr;
   logic [2:0]                  eq_rd;
   logic [3:0]                  eq_cnt;
   logic                        eq_pop;

   // Letters are folded to upper case before they reach the header.
   assign ch = (rx_data_i >= acp_pkg::CH_LO_A && rx_data_i <= acp_pkg::CH_LO_Z)
             ? rx_data_i - acp_pkg::CH_CASE : rx_data_i;
   assign is_ws   = (ch == acp_pkg::CH_SP) || (ch == acp_pkg::CH_TAB);
   assign rx_fire = rx_valid_i && rx_ready_o;

   for (genvar i = 0; i < acp_pkg::HDR_CHARS; i++) begin : g_swap
      assign hdr_swap[8*i +: 8] = hdr[8*(i ^ 1) +: 8];
   end

   acp_kw_match u_match (
      .text_i (hdr),
      .hit_o  (hit),
      .idx_o  (kw_idx)
   );

   // Odd-length headers pair their first character with padding.
   acp_kw_match u_swap_match (
      .text_i (hdr_swap),
      .hit_o  (swap_hit),
      .idx_o  ()
   );

   assign par_bad = bad || (in_par && field_empty)
                 || (in_par && acp_pkg::KW_NOPARAM[kw_idx]);
   assign exec_ok = hit && !over && !par_bad;

   always_comb begin
      next_state = state;
      unique case (state)
         M_RECV: begin
            if (rx_fire && ch == acp_pkg::CH_LF) begin
               next_state = M_EXEC;
            end
         end
         M_EXEC: begin
            if (exec_ok && kw_idx == acp_pkg::KW_IDN) begin
               next_state = M_SEND;
            end else if (exec_ok && kw_idx == acp_pkg::KW_TST) begin
               next_state = M_TEST;
            end else begin
               next_state = M_RECV;
            end
         end
         M_TEST: begin
            if (st_finish) begin
               next_state = M_SEND;
            end
         end
         M_SEND: begin
            if (tx_valid_o && tx_ready_i && tx_last_o) begin
               next_state = M_RECV;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         state      <= M_RECV;
         rx_ready_o <= 1'b0;
      end else begin
         state      <= next_state;
         rx_ready_o <= (next_state == M_RECV);
      end
   end

   // Message collection: header up to the first white space, then fields.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i || state == M_EXEC) begin
         hdr         <= '0;
         hlen        <= 5'h00;
         over        <= 1'b0;
         in_par      <= 1'b0;
         field_empty <= 1'b0;
         bad         <= 1'b0;
         ncomma      <= 4'h0;
         pval        <= 16'h0000;
      end else if (rx_fire && ch != acp_pkg::CH_LF) begin
         if (!in_par) begin
            if (is_ws) begin
               in_par      <= 1'b1;
               field_empty <= 1'b1;
            end else if (ch == acp_pkg::CH_NUL || hlen == acp_pkg::HLEN_MAX) begin
               over <= 1'b1;
            end else begin
               // A colon is stored like any other keyword character.
               hdr  <= {hdr[acp_pkg::HDR_W-9:0], ch};
               hlen <= hlen + 5'h01;
            end
         end else if (is_ws) begin
            bad <= 1'b1;
         end else if (ch == acp_pkg::CH_COMMA) begin
            if (field_empty || ncomma == 4'hf) begin
               bad <= 1'b1;
            end
            ncomma      <= ncomma + 4'h1;
            field_empty <= 1'b1;
         end else begin
            field_empty <= 1'b0;
            if (ncomma == 4'h0 && ch >= acp_pkg::CH_ZERO
                && ch <= acp_pkg::CH_NINE) begin
               pval <= 16'(pval * 16'h000a + 16'(ch - acp_pkg::CH_ZERO));
            end
         end
      end
   end

   // Accepted commands are handed on; refused ones raise no strobe, abort or reset pulse.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         cmd_strobe_o   <= 1'b0;
         cmd_code_o     <= 5'h00;
         cmd_param_o    <= 16'h0000;
         cmd_nparam_o   <= 4'h0;
         abort_o        <= 1'b0;
         settings_rst_o <= 1'b0;
      end else begin
         cmd_strobe_o   <= (state == M_EXEC) && exec_ok;
         abort_o        <= 1'b0;
         settings_rst_o <= 1'b0;
         if (state == M_EXEC && exec_ok) begin
            cmd_code_o   <= kw_idx;
            cmd_param_o  <= pval;
            cmd_nparam_o <= in_par ? ncomma + 4'h1 : 4'h0;
            // Only a non-zero idle value stops the measurement.
            abort_o      <= acp_pkg::KW_ABORT[kw_idx]
                         || (kw_idx == acp_pkg::KW_MEAS_CONTROL
                             && pval != 16'h0000);
            // Calibration storage has no path from this pulse.
            settings_rst_o <= (kw_idx == acp_pkg::KW_RST);
         end
      end
   end

   // Self-test sequencer with a watchdog sized by installed memory.
   assign limit = 8'(acp_pkg::ST_TENTHS[mem_size_i] * acp_pkg::ST_MARGIN);
   assign timeout   = (state == M_TEST) && (tenths >= limit);
   assign st_finish = (state == M_TEST) && (timeout || (st_done_i
                      && !st_start_o && stage == acp_pkg::STG_ANALOG));
   assign st_result_fail = fail || timeout || (st_done_i && st_fail_i);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         st_start_o <= 1'b0;
         stage      <= acp_pkg::STG_DIGITAL;
         fail       <= 1'b0;
         pre        <= 32'h0000_0000;
         tenths     <= 8'h00;
      end else if (state == M_EXEC && next_state == M_TEST) begin
         st_start_o <= 1'b1;
         stage      <= acp_pkg::STG_DIGITAL;
         fail       <= 1'b0;
         pre        <= 32'h0000_0000;
         tenths     <= 8'h00;
      end else if (state == M_TEST) begin
         st_start_o <= 1'b0;
         if (pre == 32'(TENTH_MIN_CYC - 1)) begin
            pre    <= 32'h0000_0000;
            tenths <= tenths + 8'h01;
         end else begin
            pre <= pre + 32'h0000_0001;
         end
         if (st_done_i && !st_start_o) begin
            fail <= fail || st_fail_i;
            if (stage != acp_pkg::STG_ANALOG && !timeout) begin
               // Noise, bump, memory and analog stages follow in turn.
               stage      <= stage + 3'h1;
               st_start_o <= 1'b1;
            end
         end
      end
   end
   assign st_stage_o = stage;

   // Replies: identification text or the self-test digit, then a line feed.
   function automatic logic [7:0] idn_char(input logic [5:0] p);
      return acp_pkg::IDN_TEXT[8*(acp_pkg::IDN_LEN - 1 - int'(p)) +: 8];
   endfunction : idn_char

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         tx_data_o  <= 8'h00;
         tx_valid_o <= 1'b0;
         tx_last_o  <= 1'b0;
         ptr        <= 6'h00;
         resp_idn   <= 1'b0;
      end else if (state != M_SEND && next_state == M_SEND) begin
         tx_valid_o <= 1'b1;
         tx_last_o  <= 1'b0;
         ptr        <= 6'h00;
         resp_idn   <= (state == M_EXEC);
         if (state == M_EXEC) begin
            tx_data_o <= idn_char(6'h00);
         end else begin
            tx_data_o <= st_result_fail ? acp_pkg::RES_FAIL
                                        : acp_pkg::RES_PASS;
         end
      end else if (tx_valid_o && tx_ready_i) begin
         if (tx_last_o) begin
            tx_valid_o <= 1'b0;
            tx_last_o  <= 1'b0;
         end else begin
            ptr <= ptr + 6'h01;
            if (resp_idn && ptr < 6'(acp_pkg::IDN_LEN - 1)) begin
               tx_data_o <= idn_char(ptr + 6'h01);
            end else begin
               tx_data_o <= acp_pkg::CH_LF;
               tx_last_o <= 1'b1;
            end
         end
      end
   end

   // Error queue; a full queue drops the newest entry.
   always_comb begin
      err_push = 1'b0;
      err_val  = acp_pkg::ERR_PARM;
      if (state == M_EXEC && !exec_ok) begin
         err_push = 1'b1;
         if (over || !hit) begin
            err_val = (swap_hit && !over) ? acp_pkg::ERR_BYTESWAP
                                          : acp_pkg::ERR_BAD_CMD;
         end
      end else if (st_finish && st_result_fail) begin
         err_push = 1'b1;
         err_val  = acp_pkg::ERR_SELFTEST;
      end
   end

   assign eq_pop = err_pop_i && (eq_cnt != 4'h0);

   always_ff @(posedge sys_clk_i) begin
      if (err_push && eq_cnt != acp_pkg::EQ_FULL) begin
         eq_mem[eq_wr] <= err_val;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         eq_wr       <= 3'h0;
         eq_rd       <= 3'h0;
         eq_cnt      <= 4'h0;
         err_code_o  <= 8'h00;
         err_avail_o <= 1'b0;
      end else begin
         if (err_push && eq_cnt != acp_pkg::EQ_FULL) begin
            eq_wr <= eq_wr + 3'h1;
         end
         if (eq_pop) begin
            eq_rd      <= eq_rd + 3'h1;
            err_code_o <= eq_mem[eq_rd];
         end
         if (err_push && eq_cnt != acp_pkg::EQ_FULL && !eq_pop) begin
            eq_cnt      <= eq_cnt + 4'h1;
            err_avail_o <= 1'b1;
         end else if (eq_pop && !(err_push && eq_cnt != acp_pkg::EQ_FULL)) begin
            eq_cnt      <= eq_cnt - 4'h1;
            err_avail_o <= (eq_cnt != 4'h1);
         end
      end
   end

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   chk_reset_aborts: assert property (
      state == M_EXEC && exec_ok && kw_idx == acp_pkg::KW_RST
      |=> abort_o && settings_rst_o && cmd_strobe_o)
      else $error("reset command did not abort and restore");

   chk_meas_ctl_zero: assert property (
      state == M_EXEC && exec_ok && kw_idx == acp_pkg::KW_MEAS_CONTROL
      && pval == 16'h0000 |=> !abort_o)
      else $error("measurement control with zero value aborted");

   chk_header_upper: assert property (
      rx_fire && !in_par && !is_ws && rx_data_i != acp_pkg::CH_LF
      && hlen != acp_pkg::HLEN_MAX && rx_data_i != acp_pkg::CH_NUL
      |=> !(hdr[7:0] >= acp_pkg::CH_LO_A && hdr[7:0] <= acp_pkg::CH_LO_Z))
      else $error("lower-case letter kept in header");

   chk_bad_cmd_err: assert property (
      state == M_EXEC && !hit && eq_cnt < 4'h7 && !err_pop_i
      |=> !cmd_strobe_o && !abort_o && eq_cnt == $past(eq_cnt) + 4'h1
      ##1 state == M_RECV || rx_ready_o)
      else $error("unknown header not queued or not refused");

   chk_swap_code: assert property (
      state == M_EXEC && !hit && swap_hit && !over
      |-> err_push && err_val == acp_pkg::ERR_BYTESWAP)
      else $error("byte-swapped header gave wrong error");

   chk_ws_refused: assert property (
      rx_fire && in_par && is_ws |=> par_bad throughout
      (state == M_RECV)[*1] ##1 !cmd_strobe_o)
      else $error("white space in parameters not refused");

   chk_test_pass: assert property (
      st_finish && !st_result_fail
      |=> tx_valid_o && tx_data_o == acp_pkg::RES_PASS ##0 !tx_last_o)
      else $error("passing self-test did not answer zero");

   chk_test_fail: assert property (
      st_finish && st_result_fail && eq_cnt < 4'h7 && !err_pop_i
      |=> tx_data_o == acp_pkg::RES_FAIL && eq_cnt == $past(eq_cnt) + 4'h1)
      else $error("failing self-test did not answer one and queue");

   chk_stage_order: assert property (
      st_start_o && stage != acp_pkg::STG_DIGITAL
      |-> $past(st_done_i) && $past(state) == M_TEST)
      else $error("self-test stage started without prior completion");

   chk_idn_start: assert property (
      state == M_EXEC && exec_ok && kw_idx == acp_pkg::KW_IDN
      |=> tx_valid_o && tx_data_o == idn_char(6'h00) && resp_idn)
      else $error("identification reply did not start");

endmodule : acp_parser

// ### verilog/acp_pkg.sv
package acp_pkg;

   // Header capture and character codes.
   localparam int          HDR_CHARS = 16;
   localparam int          HDR_W     = 8 * HDR_CHARS;
   localparam logic [4:0]  HLEN_MAX  = 5'h10;
   localparam logic [7:0]  CH_NUL    = 8'h00;
   localparam logic [7:0]  CH_TAB    = 8'h09;
   localparam logic [7:0]  CH_LF     = 8'h0a;
   localparam logic [7:0]  CH_SP     = 8'h20;
   localparam logic [7:0]  CH_COMMA  = 8'h2c;
   localparam logic [7:0]  CH_ZERO   = 8'h30;
   localparam logic [7:0]  CH_NINE   = 8'h39;
   localparam logic [7:0]  CH_LO_A   = 8'h61;
   localparam logic [7:0]  CH_LO_Z   = 8'h7a;
   localparam logic [7:0]  CH_CASE   = 8'h20;
   localparam logic [7:0]  RES_PASS  = 8'h30;
   localparam logic [7:0]  RES_FAIL  = 8'h31;

   // Keyword table; text is right aligned, last character in the low byte.
   localparam int          KW_NUM          = 20;
   localparam logic [4:0]  KW_IDN          = 5'h00;
   localparam logic [4:0]  KW_RST          = 5'h01;
   localparam logic [4:0]  KW_TST          = 5'h02;
   localparam logic [4:0]  KW_MEAS_CONTROL = 5'h03;
   localparam logic [HDR_W-1:0] KW_TEXT [KW_NUM] = '{
      HDR_W'("*IDN?"),           HDR_W'("*RST"),
      HDR_W'("*TST?"),           HDR_W'("MEAS:CONTROL"),
      HDR_W'("MEAS:START"),      HDR_W'("INIT"),
      HDR_W'("INPUT:AUTOZERO"),  HDR_W'("CLOCK:SETUP"),
      HDR_W'("CLOCK:DSP"),       HDR_W'("CLOCK:MASTER"),
      HDR_W'("CLOCK:MULTI:SYNC"), HDR_W'("CLOCK:SOURCE"),
      HDR_W'("DATA:MODE"),       HDR_W'("DATA:PORT"),
      HDR_W'("DATA:TYPE"),       HDR_W'("DATA:RESOLUTION"),
      HDR_W'("FILTER:SETUP"),    HDR_W'("LBUS:MODE"),
      HDR_W'("DATA:BLOCKSIZE"),  HDR_W'("FILTER:DECIMATE")};
   localparam logic [KW_NUM-1:0] KW_ABORT   = 20'hffff2;
   localparam logic [KW_NUM-1:0] KW_NOPARAM = 20'h00077;

   // Error codes pushed onto the error queue.
   localparam logic [7:0]  ERR_BAD_CMD  = 8'h61;
   localparam logic [7:0]  ERR_PARM     = 8'h62;
   localparam logic [7:0]  ERR_SELFTEST = 8'h6a;
   localparam logic [7:0]  ERR_BYTESWAP = 8'h7f;
   localparam int          EQ_DEPTH     = 8;
   localparam logic [3:0]  EQ_FULL      = 4'h8;

   // Identification reply; every field value is arbitrary.
   localparam int          IDN_LEN  = 29;
   localparam logic [8*IDN_LEN-1:0] IDN_TEXT =
      "NOMAKER,DIGI-A,SN000000,1:1:1";

   // Self-test stages and durations in tenths of a minute.
   localparam logic [2:0]  STG_DIGITAL = 3'h0;
   localparam logic [2:0]  STG_ANALOG  = 3'h4;
   localparam logic [7:0]  ST_TENTHS [4] = '{8'h0a, 8'h0f, 8'h19, 8'h2d};
   localparam logic [7:0]  ST_MARGIN   = 8'h02;
   localparam int          CLK_HZ      = 125_000_000;
   localparam int          TENTH_MIN_S = 6;
   localparam int          TENTH_MIN_CYC = TENTH_MIN_S * CLK_HZ;

endpackage : acp_pkg

// ### verilog/acp_kw_match.sv
`timescale 1ns/10ps
module acp_kw_match (
   input  wire logic [acp_pkg::HDR_W-1:0] text_i,
   output logic                           hit_o,
   output logic [4:0]                     idx_o
);
   logic [acp_pkg::KW_NUM-1:0] eq;

   // Whole-text compare only, so a shortened keyword never matches.
   for (genvar g = 0; g < acp_pkg::KW_NUM; g++) begin : g_kw
      assign eq[g] = (text_i == acp_pkg::KW_TEXT[g]);
   end

   always_comb begin
      hit_o = 1'b0;
      idx_o = 5'h00;
      for (int k = acp_pkg::KW_NUM - 1; k >= 0; k--) begin
         if (eq[k]) begin
            hit_o = 1'b1;
            idx_o = 5'(k);
         end
      end
   end
endmodule : acp_kw_match

// ### tb/acp_host_model.sv
`timescale 1ns/10ps
module acp_host_model (
   input  wire logic       sys_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       st_start_i,
   input  wire logic [2:0] st_stage_i,
   input  wire logic [2:0] fail_stage_i,
   output logic            st_done_o,
   output logic            st_fail_o,
   output logic            tx_ready_o
);
   int unsigned wait_cnt;
   logic [2:0]  stage;

   // The sink stalls at random, so every reply byte has to stand until taken.
   always_ff @(posedge sys_clk_i) begin
      tx_ready_o <= rst_b_i && ($urandom_range(0, 3) != 0);
   end

   // A stage takes a few cycles, so done never lands in the start cycle.
   // A fail_stage_i of 6 swallows the done pulse, so only the watchdog can end it.
   always_ff @(posedge sys_clk_i) begin
      st_done_o <= 1'b0;
      st_fail_o <= 1'b0;
      if (!rst_b_i) begin
         wait_cnt <= 0;
      end else if (st_start_i) begin
         wait_cnt <= 2 + $urandom_range(0, 3);
         stage    <= st_stage_i;
      end else if (wait_cnt == 1 && fail_stage_i != 3'h6) begin
         wait_cnt  <= 0;
         st_done_o <= 1'b1;
         st_fail_o <= (stage == fail_stage_i);
      end else if (wait_cnt != 0) begin
         wait_cnt <= wait_cnt - 1;
      end
   end
endmodule : acp_host_model

// ### tb/acp_parser_bench.sv
`timescale 1ns/10ps
module acp_parser_bench;
   logic        sys_clk_i, rst_b_i, rx_valid_i, tx_ready_i, err_pop_i;
   logic        st_done_i, st_fail_i, rx_ready_o, tx_valid_o, tx_last_o;
   logic        cmd_strobe_o, abort_o, settings_rst_o, st_start_o, err_avail_o;
   logic [7:0]  rx_data_i, tx_data_o, err_code_o;
   logic [4:0]  cmd_code_o;
   logic [15:0] cmd_param_o;
   logic [3:0]  cmd_nparam_o;
   logic [2:0]  st_stage_o, stg_exp, fail_stage;
   logic [1:0]  mem_size_i;
   logic [8:0]  rq[$];
   logic [7:0]  eq[$];
   int          error_cnt = 0;
   int          num_checks = 0;
   int          cyc = 0;

   acp_parser #(.TENTH_MIN_CYC(10)) acp_parser_i (.sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
      .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
      .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
      .cmd_strobe_o(cmd_strobe_o), .cmd_code_o(cmd_code_o),
      .cmd_param_o(cmd_param_o), .cmd_nparam_o(cmd_nparam_o),
      .abort_o(abort_o), .settings_rst_o(settings_rst_o),
      .st_start_o(st_start_o), .st_stage_o(st_stage_o), .st_done_i(st_done_i),
      .st_fail_i(st_fail_i), .mem_size_i(mem_size_i), .err_pop_i(err_pop_i),
      .err_code_o(err_code_o), .err_avail_o(err_avail_o));

   acp_host_model acp_host_model_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .st_start_i(st_start_o), .st_stage_i(st_stage_o),
      .fail_stage_i(fail_stage), .st_done_o(st_done_i),
      .st_fail_o(st_fail_i), .tx_ready_o(tx_ready_i));

   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   task automatic test_done;
      if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : check

   // Replies and stage starts are sampled before the edge lands.
   always @(posedge sys_clk_i) begin
      cyc++;
      if (tx_valid_o === 1'b1 && tx_ready_i) rq.push_back({tx_last_o, tx_data_o});
      if (st_start_o === 1'b1) begin
         check(st_stage_o, stg_exp);
         stg_exp++;
      end
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic put_byte(input logic [7:0] b);
      rx_data_i  <= b;
      rx_valid_i <= 1'b1;
      do @(negedge sys_clk_i); while (rx_ready_o !== 1'b1);
      @(posedge sys_clk_i);
   endtask : put_byte

   task automatic send(input string s);
      foreach (s[i]) put_byte(s[i]);
      put_byte(acp_pkg::CH_LF);
      rx_valid_i <= 1'b0;
   endtask : send

   task automatic drain;
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      while (err_avail_o === 1'b1) begin
         @(posedge sys_clk_i) err_pop_i <= 1'b1;
         @(posedge sys_clk_i) err_pop_i <= 1'b0;
         @(negedge sys_clk_i);
         check(err_code_o, eq.size() ? eq.pop_front() : 8'hff);
      end
      check(eq.size(), 0);
      @(posedge sys_clk_i);
   endtask : drain

   task automatic run(input string s, input logic [4:0] code,
                      input logic [15:0] par, input logic [3:0] np,
                      input bit ab, input bit sr, input logic [7:0] err);
      send(s);
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      check(cmd_strobe_o, err == 0);
      check(rx_ready_o, 1'b1);
      check(abort_o, ab);
      check(settings_rst_o, sr);
      if (err == 0) begin
         check(cmd_code_o, code);
         check(cmd_nparam_o, np);
         if (np != 0) check(cmd_param_o, par);
      end else eq.push_back(err);
      drain();
   endtask : run

   task automatic reply(input string s);
      while (rq.size() < s.len() + 1) @(posedge sys_clk_i);
      foreach (s[i]) check(rq.pop_front(), {1'b0, s[i]});
      check(rq.pop_front(), {1'b1, acp_pkg::CH_LF});
   endtask : reply

   initial begin
      string            s;
      logic [7:0]       c;
      logic [127:0]     t;
      int               v;
      int               np;
      rst_b_i    = 1'b0;
      rx_valid_i = 1'b0;
      rx_data_i  = 8'h00;
      err_pop_i  = 1'b0;
      mem_size_i = 2'h0;
      fail_stage = 3'h7;
      stg_exp    = 3'h0;
      void'($urandom(32'h0166));
      repeat (3) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      @(posedge sys_clk_i);
      // Every keyword but the two queries, in random letter case.
      for (int rep = 0; rep < 2; rep++) begin
         for (int k = 1; k < acp_pkg::KW_NUM; k++) begin
            if (k == 2) continue;
            s = "";
            t = acp_pkg::KW_TEXT[k];
            for (int i = acp_pkg::HDR_CHARS - 1; i >= 0; i--) begin
               c = t[8*i +: 8];
               if (c >= 8'h41 && c <= 8'h5a && $urandom_range(0, 1)) c = c | 8'h20;
               if (c != 8'h00) s = $sformatf("%s%c", s, c);
            end
            v  = (k == 3 && rep == 0) ? 0 : $urandom_range(1, 999);
            np = 0;
            if (!acp_pkg::KW_NOPARAM[k]) begin
               np = 1 + rep;
               s  = $sformatf("%s%s%0d", s, rep ? "\t" : " ", v);
               if (rep) s = $sformatf("%s,%0d", s, $urandom_range(0, 99));
            end
            run(s, k[4:0], v[15:0], np[3:0], k != 3 || v != 0, k == 1, 8'h00);
         end
      end
      run("MEAS:STAR", 5'h0, 16'h0, 4'h0, 1'b0, 1'b0, 8'h61);
      run("*R ST", 5'h0, 16'h0, 4'h0, 1'b0, 1'b0, 8'h61);
      run("DATA:MODE 1,,2", 5'h0, 16'h0, 4'h0, 1'b0, 1'b0, 8'h62);
      run("INIT 1", 5'h0, 16'h0, 4'h0, 1'b0, 1'b0, 8'h62);
      run("DATA:PORT  1", 5'h0, 16'h0, 4'h0, 1'b0, 1'b0, 8'h62);
      run("R*TS", 5'h0, 16'h0, 4'h0, 1'b0, 1'b0, 8'h7f);
      send("*idN?");
      reply($sformatf("%s", acp_pkg::IDN_TEXT));
      drain();
      // Passing self-tests at memory sizes 0 and 2, failing ones at sizes 1 and 3.
      for (int n = 0; n < 4; n++) begin
         mem_size_i <= n[1:0];
         fail_stage <= n[0] ? 3'($urandom_range(0, 4)) : 3'h7;
         stg_exp = 3'h0;
         send("*tst?");
         reply(n[0] ? "1" : "0");
         if (n[0]) eq.push_back(acp_pkg::ERR_SELFTEST);
         drain();
         check(stg_exp, 3'h5);
      end
      // A stage that never finishes must be ended by the watchdog.
      // With ten cycles to a tenth, the reply lands between 900 and 999 cycles.
      mem_size_i <= 2'h3;
      fail_stage <= 3'h6;
      stg_exp = 3'h0;
      send("*tst?");
      v = cyc;
      reply("1");
      v = cyc - v;
      check(v / 100, acp_pkg::ST_TENTHS[3] * acp_pkg::ST_MARGIN / 10);
      eq.push_back(acp_pkg::ERR_SELFTEST);
      drain();
      check(stg_exp, 3'h1);
      test_done();
   end
endmodule : acp_parser_bench
